/* File: design/ebict_top.sv */
// External bus timing for four chip-select spaces with idle insertion
// and chip-select widening, configured over a classic Wishbone slave.
// Assumes one 50 MHz clock, requests synchronous to it, and external
// memories that answer within the two basic states.
//
// Overview of operation
// - A 16-bit read/write control register holds all per-space timing.
// - Power-on reset and hardware standby load all ones into it.
// - Manual reset and software standby leave the register untouched.
// - After a read, idle cycles precede an access to another space.
// - A write right after a read to one space still gets idles.
// - Idle count comes from the previous access's space setting.
// - Idle fields: space 3 bits 15:14 down to space 0 bits 9:8.
// - Idle field codes 00..11 mean zero to three cycles.
// - Same-space option negates the select once between accesses.
// - Bits 7..4 hold the same-space option, one means one cycle.
// - Bit 7 serves space 3 down to bit 4 for space 0.
// - Write after read to one space uses the larger of both idle settings.
// - With widening, strobes stay inside the select assert period.
// - Widening adds a cycle before and after, holding write data.
// - Bits 3..0 enable widening per space, one by default.
// - A basic access takes two states before any added cycles.
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "ebict_cfg.svh"

module ebict_top (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    // Power state controls.
    input  wire logic                          hwStandby,
    input  wire logic                          manualReset,
    input  wire logic                          swStandby,
    // Wishbone register slave.
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [`EBICT_WB_AW-1:0]       wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // Access requests from the core side.
    input  wire logic                          reqValid,
    input  wire ebict_pkg::ebict_req_t         req,
    output logic                               reqReady,
    output logic                               accessDone,
    output logic      [`EBICT_DATA_W-1:0]      readData,
    // External bus pins.
    output logic      [`EBICT_SPACES-1:0]      spaceSelectN,
    output logic                               readStrobeN,
    output logic                               writeStrobeUpperN,
    output logic                               writeStrobeLowerN,
    output logic      [`EBICT_ADDR_W-1:0]      extAddr,
    output logic      [`EBICT_DATA_W-1:0]      extDataOut,
    output logic                               extDataOe,
    input  wire logic [`EBICT_DATA_W-1:0]      extDataIn
);

    // ------------------------------------------------------------------
    // State and reset image
    // ------------------------------------------------------------------
    localparam ebict_pkg::ebict_pins_t PINS_IDLE = '{
        spaceSelectN:      {`EBICT_SPACES{1'b1}},
        readStrobeN:       1'b1,
        writeStrobeUpperN: 1'b1,
        writeStrobeLowerN: 1'b1,
        dataOe:            1'b0
    };

    localparam ebict_pkg::ebict_regs_t REGS_RST = '{
        ctrl:     `EBICT_CTRL_RST,
        state:    ebict_pkg::ST_IDLE,
        gapCnt:   2'h0,
        sinceEnd: 2'h3,
        used:     1'b0,
        cur:      '0,
        pins:     PINS_IDLE,
        rdata:    '0,
        done:     1'b0,
        wbAck:    1'b0,
        wbDat:    32'h0
    };

    ebict_pkg::ebict_regs_t s;
    ebict_pkg::ebict_regs_t next_s;

    // ------------------------------------------------------------------
    // Request acceptance
    // ------------------------------------------------------------------
    logic       curWiden;
    logic       lastCycle;
    logic       busHold;
    logic       accept;
    logic [2:0] elapsed;
    logic [1:0] need;

    assign curWiden  = ebict_pkg::select_widen(s.ctrl, s.cur.space);
    // A new access may follow in the cycle after the last busy one, so a
    // zero idle setting really gives no idle cycle.
    assign lastCycle = (s.state == ebict_pkg::ST_POST) ||
                       (s.state == ebict_pkg::ST_T2 && !curWiden);
    assign busHold   = hwStandby | manualReset | swStandby;
    assign reqReady  = ce && !busHold &&
                       (s.state == ebict_pkg::ST_IDLE || lastCycle);
    assign accept    = reqValid && reqReady;
    // Only bus cycles with every select negated count as idle.
    assign elapsed   = (s.state == ebict_pkg::ST_IDLE) ? ({1'b0, s.sinceEnd} + 3'h1) : 3'h0;

    ebict_gap_calc u_gap (
        .ctrl      (s.ctrl),
        .prevValid (s.used),
        .prevSpace (s.cur.space),
        .prevWrite (s.cur.write),
        .nextSpace (req.space),
        .nextWrite (req.write),
        .elapsed   (elapsed),
        .need      (need)
    );

    // ------------------------------------------------------------------
    // Pin image for a given state
    // ------------------------------------------------------------------
    function automatic ebict_pkg::ebict_pins_t pins_of(input ebict_pkg::ebict_regs_t r);
        logic busy;
        logic strobe;
        pins_of = PINS_IDLE;
        busy    = (r.state == ebict_pkg::ST_PRE) || (r.state == ebict_pkg::ST_T1) ||
                  (r.state == ebict_pkg::ST_T2) || (r.state == ebict_pkg::ST_POST);
        strobe  = (r.state == ebict_pkg::ST_T1) || (r.state == ebict_pkg::ST_T2);
        if (busy) begin
            pins_of.spaceSelectN[r.cur.space] = 1'b0;
        end
        if (strobe && !r.cur.write) begin
            pins_of.readStrobeN = 1'b0;
        end
        if (strobe && r.cur.write) begin
            pins_of.writeStrobeUpperN = !r.cur.sel[1];
            pins_of.writeStrobeLowerN = !r.cur.sel[0];
        end
        pins_of.dataOe = r.cur.write && (strobe || r.state == ebict_pkg::ST_POST);
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic regHit;
    logic wbHit;

    assign wbHit  = wb_cyc_i && wb_stb_i && !s.wbAck;
    assign regHit = (wb_adr_i == `EBICT_CTRL_OFS);

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;

        // Wishbone slave: one wait cycle, then a one-cycle acknowledge.
        next_s.wbAck = wbHit;
        if (wbHit) begin
            next_s.wbDat = regHit ? {16'h0, s.ctrl} : 32'h0;
            if (wb_we_i && regHit) begin
                if (wb_sel_i[0]) begin
                    next_s.ctrl[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    next_s.ctrl[15:8] = wb_dat_i[15:8];
                end
            end
        end

        // Idle counter saturates; it only has to reach the largest gap.
        if (s.state == ebict_pkg::ST_IDLE && {1'b0, s.sinceEnd} != `EBICT_GAP_MAX) begin
            next_s.sinceEnd = s.sinceEnd + 2'h1;
        end

        case (s.state)
            ebict_pkg::ST_IDLE: begin
                next_s.state = ebict_pkg::ST_IDLE;
            end
            ebict_pkg::ST_GAP: begin
                if (s.gapCnt == 2'h0) begin
                    next_s.state = ebict_pkg::select_widen(s.ctrl, s.cur.space) ?
                                   ebict_pkg::ST_PRE : ebict_pkg::ST_T1;
                end else begin
                    next_s.gapCnt = s.gapCnt - 2'h1;
                end
            end
            ebict_pkg::ST_PRE: begin
                next_s.state = ebict_pkg::ST_T1;
            end
            ebict_pkg::ST_T1: begin
                next_s.state = ebict_pkg::ST_T2;
            end
            ebict_pkg::ST_T2: begin
                // Read data is taken at the end of the second state.
                if (!s.cur.write) begin
                    next_s.rdata = extDataIn;
                end
                next_s.done     = 1'b1;
                next_s.sinceEnd = 2'h0;
                next_s.state    = curWiden ? ebict_pkg::ST_POST : ebict_pkg::ST_IDLE;
            end
            ebict_pkg::ST_POST: begin
                next_s.sinceEnd = 2'h0;
                next_s.state    = ebict_pkg::ST_IDLE;
            end
            default: begin
                next_s.state = ebict_pkg::ST_IDLE;
            end
        endcase

        // A newly taken request overrides the end of the previous one.
        if (accept) begin
            next_s.cur  = req;
            next_s.used = 1'b1;
            if (need != 2'h0) begin
                next_s.state  = ebict_pkg::ST_GAP;
                next_s.gapCnt = need - 2'h1;
            end else begin
                next_s.state = ebict_pkg::select_widen(s.ctrl, req.space) ?
                               ebict_pkg::ST_PRE : ebict_pkg::ST_T1;
            end
        end

        if (manualReset) begin
            next_s.state    = ebict_pkg::ST_IDLE;
            next_s.used     = 1'b0;
            next_s.sinceEnd = 2'h3;
            next_s.done     = 1'b0;
        end

        if (hwStandby) begin
            next_s.ctrl     = `EBICT_CTRL_RST;
            next_s.state    = ebict_pkg::ST_IDLE;
            next_s.used     = 1'b0;
            next_s.sinceEnd = 2'h3;
            next_s.done     = 1'b0;
        end

        // Pins are registered from the state they belong to, so they
        // change cleanly on the clock edge with no decode glitches.
        next_s.pins = pins_of(next_s);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= REGS_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o          = s.wbAck;
    assign wb_dat_o          = s.wbDat;
    assign accessDone        = s.done;
    assign readData          = s.rdata;
    assign spaceSelectN      = s.pins.spaceSelectN;
    assign readStrobeN       = s.pins.readStrobeN;
    assign writeStrobeUpperN = s.pins.writeStrobeUpperN;
    assign writeStrobeLowerN = s.pins.writeStrobeLowerN;
    assign extDataOe         = s.pins.dataOe;
    assign extAddr           = s.cur.addr;
    assign extDataOut        = s.cur.wdata;

endmodule

/* File: design/ebict_cfg.svh */
// Constants of the external bus idle and chip-select timing block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef EBICT_CFG_SVH
`define EBICT_CFG_SVH

// ----------------------------------------------------------------------
// Register map and field layout
// ----------------------------------------------------------------------
`define EBICT_WB_AW        8
`define EBICT_CTRL_OFS     8'h00
`define EBICT_CTRL_W       16
`define EBICT_CTRL_RST     16'hffff
`define EBICT_IW_LSB       8
`define EBICT_CW_LSB       4
`define EBICT_SW_LSB       0

// ----------------------------------------------------------------------
// Bus geometry and counts
// ----------------------------------------------------------------------
`define EBICT_SPACES       4
`define EBICT_ADDR_W       22
`define EBICT_DATA_W       16
`define EBICT_GAP_MAX      3'h3

`endif

/* File: design/ebict_pkg.sv */
// Types and field decoders shared by the bus timing block.
// Assumes the constant header ebict_cfg.svh is on the include path.
`include "ebict_cfg.svh"

package ebict_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_GAP  = 3'b001,
        ST_PRE  = 3'b010,
        ST_T1   = 3'b011,
        ST_T2   = 3'b100,
        ST_POST = 3'b101
    } ebict_state_t;

    typedef struct packed {
        logic [1:0]                 space;
        logic                       write;
        logic [1:0]                 sel;
        logic [`EBICT_ADDR_W-1:0]   addr;
        logic [`EBICT_DATA_W-1:0]   wdata;
    } ebict_req_t;

    typedef struct packed {
        logic [`EBICT_SPACES-1:0]   spaceSelectN;
        logic                       readStrobeN;
        logic                       writeStrobeUpperN;
        logic                       writeStrobeLowerN;
        logic                       dataOe;
    } ebict_pins_t;

    typedef struct packed {
        logic [`EBICT_CTRL_W-1:0]   ctrl;
        ebict_state_t               state;
        logic [1:0]                 gapCnt;
        logic [1:0]                 sinceEnd;
        logic                       used;
        ebict_req_t                 cur;
        ebict_pins_t                pins;
        logic [`EBICT_DATA_W-1:0]   rdata;
        logic                       done;
        logic                       wbAck;
        logic [31:0]                wbDat;
    } ebict_regs_t;

    // ------------------------------------------------------------------
    // Field decoders
    // ------------------------------------------------------------------
    function automatic logic [1:0] idle_cycles(input logic [`EBICT_CTRL_W-1:0] ctrl,
                                               input logic [1:0] space);
        idle_cycles = ctrl[`EBICT_IW_LSB + 2*space +: 2];
    endfunction

    function automatic logic same_gap(input logic [`EBICT_CTRL_W-1:0] ctrl,
                                      input logic [1:0] space);
        same_gap = ctrl[`EBICT_CW_LSB + space];
    endfunction

    function automatic logic select_widen(input logic [`EBICT_CTRL_W-1:0] ctrl,
                                          input logic [1:0] space);
        select_widen = ctrl[`EBICT_SW_LSB + space];
    endfunction

endpackage

/* File: design/ebict_gap_calc.sv */
// Works out how many idle cycles must still pass before the next access.
// Assumes the caller reports the previous access and the idle cycles
// already seen on the bus since it ended.
`timescale 1ns/100ps
`include "ebict_cfg.svh"

module ebict_gap_calc (
    input  wire logic [`EBICT_CTRL_W-1:0] ctrl,
    input  wire logic                     prevValid,
    input  wire logic [1:0]               prevSpace,
    input  wire logic                     prevWrite,
    input  wire logic [1:0]               nextSpace,
    input  wire logic                     nextWrite,
    input  wire logic [2:0]               elapsed,
    output logic      [1:0]               need
);

    logic [2:0] required;
    logic [2:0] iw;
    logic [2:0] cw;

    always_comb begin
        iw = {1'b0, ebict_pkg::idle_cycles(ctrl, prevSpace)};
        cw = {2'b00, ebict_pkg::same_gap(ctrl, prevSpace)};
        required = 3'h0;
        if (prevValid) begin
            if (prevSpace != nextSpace) begin
                required = prevWrite ? 3'h0 : iw;
            end else if (!prevWrite && nextWrite) begin
                required = (iw > cw) ? iw : cw;
            end else begin
                required = cw;
            end
        end
        // Cycles the bus already sat idle count toward the gap.
        if (required > elapsed) begin
            need = 2'(required - elapsed);
        end else begin
            need = 2'h0;
        end
    end

endmodule

/* File: sim/ebict_mem_model.sv */
// Behavioural memory on the external bus, four words in each of the four spaces.
// Assumes one-hot active-low selects and strobes that are registered on clk.
`timescale 1ns/100ps
`include "ebict_cfg.svh"
module ebict_mem_model (
    input  wire logic                     clk,
    input  wire logic [`EBICT_SPACES-1:0] spaceSelectN,
    input  wire logic                     readStrobeN,
    input  wire logic                     writeStrobeUpperN,
    input  wire logic                     writeStrobeLowerN,
    input  wire logic [`EBICT_ADDR_W-1:0] extAddr,
    input  wire logic [`EBICT_DATA_W-1:0] extDataOut,
    input  wire logic                     extDataOe,
    output logic      [`EBICT_DATA_W-1:0] extDataIn
);
    logic [15:0] mem [16] = '{default: 16'h0};
    logic [15:0] last = 16'h0;
    logic [3:0]  idx;
    logic        hit;

    assign idx = {~spaceSelectN[3] | ~spaceSelectN[2], ~spaceSelectN[3] | ~spaceSelectN[1], extAddr[1:0]};
    assign hit = spaceSelectN != 4'hf;
    // A released bus flips every cycle, so stale data never passes for a good read.
    assign extDataIn = (hit && !readStrobeN) ? mem[idx] : ~last;

    always @(posedge clk) begin
        last <= extDataIn;
        if (hit && extDataOe && !writeStrobeUpperN) begin
            mem[idx][15:8] <= extDataOut[15:8];
        end
        if (hit && extDataOe && !writeStrobeLowerN) begin
            mem[idx][7:0] <= extDataOut[7:0];
        end
    end
endmodule

/* File: sim/ebict_top_sva.sv */
// Port-level checker for the bus timing block, bound to every ebict_top.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps
`include "ebict_cfg.svh"
module ebict_top_sva (
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     ce,
    input wire logic                     hwStandby,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [`EBICT_WB_AW-1:0]  wb_adr_i,
    input wire logic [3:0]               wb_sel_i,
    input wire logic [31:0]              wb_dat_i,
    input wire logic [31:0]              wb_dat_o,
    input wire logic                     wb_ack_o,
    input wire logic                     accessDone,
    input wire logic [`EBICT_SPACES-1:0] spaceSelectN,
    input wire logic                     readStrobeN,
    input wire logic                     writeStrobeUpperN,
    input wire logic                     writeStrobeLowerN,
    input wire logic [`EBICT_DATA_W-1:0] extDataOut,
    input wire logic                     extDataOe
);
    // ------------------------------------------------------------------
    // Shadow of the control register
    // ------------------------------------------------------------------
    logic [15:0] mirror;
    logic        anyStb;
    logic        widenCur;

    assign anyStb   = !readStrobeN || !writeStrobeUpperN || !writeStrobeLowerN;
    assign widenCur = |(~spaceSelectN & mirror[3:0]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mirror <= 16'hffff;
        end else if (ce && hwStandby) begin
            mirror <= 16'hffff;
        end else if (ce && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `EBICT_CTRL_OFS) begin
            mirror <= {wb_sel_i[1] ? wb_dat_i[15:8] : mirror[15:8], wb_sel_i[0] ? wb_dat_i[7:0] : mirror[7:0]};
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_strobe_two; !readStrobeN [*2]; endsequence
    sequence s_select_opens; $past(spaceSelectN) == 4'hf && spaceSelectN != 4'hf; endsequence

    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("register bus ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("register ack longer than one cycle");
    property p_reg_read; wb_ack_o && !wb_we_i && wb_adr_i == `EBICT_CTRL_OFS |-> wb_dat_o == {16'h0, mirror}; endproperty
    a_reg_read: assert property (p_reg_read) else $error("control register read wrong");
    property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i != `EBICT_CTRL_OFS |-> wb_dat_o == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_stb_in_sel; anyStb |-> $onehot(~spaceSelectN); endproperty
    a_stb_in_sel: assert property (p_stb_in_sel) else $error("strobe outside select");
    property p_one_sel; $countones(~spaceSelectN) <= 1; endproperty
    a_one_sel: assert property (p_one_sel) else $error("two selects low");
    property p_two_states; $fell(readStrobeN) |-> s_strobe_two; endproperty
    a_two_states: assert property (p_two_states) else $error("read strobe shorter than two states");
    property p_done_after; accessDone |-> $past(anyStb); endproperty
    a_done_after: assert property (p_done_after) else $error("done without a strobe cycle");
    property p_widen_pre; s_select_opens |-> anyStb == !widenCur; endproperty
    a_widen_pre: assert property (p_widen_pre) else $error("select lead cycle wrong");
    property p_widen_post;
        $past(anyStb) && !anyStb && $past(widenCur)
            |-> spaceSelectN == $past(spaceSelectN) && extDataOut == $past(extDataOut) && extDataOe == $past(extDataOe);
    endproperty
    a_widen_post: assert property (p_widen_post) else $error("select tail cycle wrong");
endmodule

bind ebict_top ebict_top_sva ebict_top_sva_inst (.*);

/* File: sim/tb.sv */
// Self-checking bench for ebict_top with a memory model on the external bus.
// Assumes the package, the header and the checker are compiled first.
`timescale 1ns/100ps
`include "ebict_cfg.svh"
module tb;
    typedef struct {int take; int lat; logic rd; logic [15:0] data;} ebict_exp_t;

    logic                  clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
    logic                  hwStandby = 1'b0, manualReset = 1'b0, swStandby = 1'b0;
    logic                  wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]            wb_adr_i = 8'h00;
    logic [3:0]            wb_sel_i = 4'h0, spaceSelectN;
    logic [31:0]           wb_dat_i = 32'h0, wb_dat_o;
    logic                  reqValid = 1'b0, reqReady, accessDone, extDataOe;
    logic                  readStrobeN, writeStrobeUpperN, writeStrobeLowerN;
    ebict_pkg::ebict_req_t req = '0;
    logic [21:0]           extAddr;
    logic [15:0]           readData, extDataOut, extDataIn, regVal = 16'hffff;
    logic [15:0]           shadow [16] = '{default: 16'h0};
    logic                  prevV = 1'b0, prevW = 1'b0;
    logic [1:0]            prevS = 2'h0;
    int                    fail_count = 0, comparisons = 0, cnt = 0, seed = 32'h85281356;
    ebict_exp_t            accQ[$], got;
    logic [31:0]           regQ[$];

    ebict_top ebict_top_inst (.*);
    ebict_mem_model ebict_mem_model_inst (.*);

    always #10 clk = ~clk;
    always @(posedge clk) cnt <= cnt + 1;

    // ------------------------------------------------------------------
    // Comparisons and verdict
    // ------------------------------------------------------------------
    task automatic report(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    task automatic chkReg(input logic [31:0] g, input logic [31:0] e);
        report(g === e, $sformatf("register read %h, expected %h", g, e));
    endtask
    task automatic chkData(input logic [15:0] g, input logic [15:0] e);
        report(g === e, $sformatf("read data %h, expected %h", g, e));
    endtask
    task automatic chkLat(input int g, input int e);
        report(g == e, $sformatf("access took %0d cycles, expected %0d", g, e));
    endtask
    task automatic results;
        $display("Summary: %0d comparisons, %0d mismatches", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic regAcc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        if (w && a == `EBICT_CTRL_OFS && s[0]) regVal[7:0] = d[7:0];
        if (w && a == `EBICT_CTRL_OFS && s[1]) regVal[15:8] = d[15:8];
        if (!w) regQ.push_back(a == `EBICT_CTRL_OFS ? {16'h0, regVal} : 32'h0);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    function automatic int gapNeed(input logic [1:0] sp, input logic w);
        int idleSet;
        int gapBit;
        idleSet = regVal[8 + 2 * prevS +: 2];
        gapBit  = regVal[4 + prevS];
        if (!prevV) return 0;
        if (sp != prevS) return prevW ? 0 : idleSet;
        if (!prevW && w) return (idleSet > gapBit) ? idleSet : gapBit;
        return gapBit;
    endfunction

    task automatic access(input logic [1:0] sp, input logic w, input logic [1:0] s, input logic [21:0] a,
                          input logic [15:0] d);
        ebict_exp_t e;
        logic [3:0] ix;
        reqValid <= 1'b1;
        req      <= '{space: sp, write: w, sel: s, addr: a, wdata: d};
        do @(negedge clk); while (reqReady !== 1'b1);
        ix     = {sp, a[1:0]};
        e.take = cnt + 1;
        e.lat  = gapNeed(sp, w) + int'(regVal[sp]) + 2;
        e.rd   = !w;
        e.data = shadow[ix];
        if (w && s[1]) shadow[ix][15:8] = d[15:8];
        if (w && s[0]) shadow[ix][7:0] = d[7:0];
        prevV = 1'b1;
        prevS = sp;
        prevW = w;
        accQ.push_back(e);
        @(posedge clk);
    endtask

    task automatic burst(input int n);
        logic [31:0] r;
        manualReset <= 1'b1;
        @(posedge clk);
        manualReset <= 1'b0;
        prevV = 1'b0;
        regAcc(1'b0, `EBICT_CTRL_OFS, 32'h0, 4'hf);
        repeat (n) begin
            r = $random(seed);
            access(r[3:2], r[4], r[1:0] == 2'h0 ? 2'h3 : r[1:0], 22'(r[12:5]), r[31:16]);
        end
        reqValid <= 1'b0;
        while (accQ.size() != 0) @(posedge clk);
    endtask

    // ------------------------------------------------------------------
    // Result monitors
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && !wb_we_i && regQ.size() != 0) chkReg(wb_dat_o, regQ.pop_front());
    end
    always @(negedge clk) begin
        if (accessDone === 1'b1 && accQ.size() != 0) begin
            got = accQ.pop_front();
            chkLat(cnt - got.take, got.lat);
            if (got.rd) chkData(readData, got.data);
        end
    end

    // Over thirty times the expected run length.
    initial begin
        #600000;
        fail_count++;
        results();
    end

    initial begin
        int k;
        logic [31:0] r;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        regAcc(1'b0, `EBICT_CTRL_OFS, 32'h0, 4'hf);
        regAcc(1'b1, 8'h04, 32'h0000_0000, 4'hf);
        regAcc(1'b0, 8'h04, 32'h0, 4'hf);
        regAcc(1'b1, `EBICT_CTRL_OFS, 32'hbeef_1234, 4'h1);
        regAcc(1'b0, `EBICT_CTRL_OFS, 32'h0, 4'hf);
        $display("Test register access done");
        for (k = 0; k < 8; k++) begin
            r = $random(seed);
            regAcc(1'b1, `EBICT_CTRL_OFS, {16'h0, {4{k[1:0]}}, r[7:0]}, 4'h3);
            burst(12);
            $display("Test burst %0d done", k);
        end
        swStandby <= 1'b1;
        @(negedge clk);
        report(reqReady === 1'b0, "request taken in software standby");
        @(posedge clk);
        swStandby <= 1'b0;
        regAcc(1'b0, `EBICT_CTRL_OFS, 32'h0, 4'hf);
        hwStandby <= 1'b1;
        @(posedge clk);
        hwStandby <= 1'b0;
        regVal = 16'hffff;
        burst(12);
        $display("Test standby done");
        results();
    end
endmodule
